// ===== design/fan_pwm_params.svh
// Purpose: Constants for the fan PWM start-up controller
// Assumes: 100 MHz system clock, word-aligned Avalon-MM registers
// Notes: Offsets are byte addresses
`ifndef FAN_PWM_PARAMS_SVH
`define FAN_PWM_PARAMS_SVH

`define CLK_HZ 100000000
`define PWM_HZ 30
`define PWM_PERIOD_CYC (`CLK_HZ / `PWM_HZ)
`define STARTUP_PERIODS 30
`define TACH_WIN_PERIODS 32
`define DUTY_MIN_PCT 30
`define DUTY_SPAN_PCT 70
`define DUTY_OPEN_CODE 4'h2
`define ANA_W 8
`define TACH_W 16

`define REG_CONFIG 5'h00
`define REG_STATUS 5'h04
`define REG_DUTY 5'h08
`define REG_FAN1_RPM 5'h0C
`define REG_FAN2_RPM 5'h10
`define REG_FAN1_LIMIT 5'h14
`define REG_FAN2_LIMIT 5'h18

`define CFG_SHUTDOWN_BIT 0
`define CFG_DUTY_SRC_BIT 5
`define STAT_FAN1_FAIL_BIT 0
`define STAT_FAN2_FAIL_BIT 1
`define STAT_OTEMP_BIT 5

`endif

// ===== design/fan_pwm_pkg.sv
// Purpose: Types for the fan PWM start-up controller
// Assumes: Constants come from fan_pwm_params.svh
// Notes: Holds the drive state enum only
package fan_pwm_pkg;
   typedef enum logic [1:0] {
      ST_OFF,
      ST_KICK,
      ST_RUN
   } drive_state_type;
endpackage

// ===== design/fan_pwm_startup_control.sv
// Purpose: Fan PWM drive with start-up kick, tach counting and fault output
// Assumes: Analog level and open flag are digitized outside; tach pulses are async
// Notes: Avalon-MM slave with one wait state per access
// Function
// RL1: Fixed-frequency PWM, only high time varies
// RL2: Applied duty clamped to 30..100 percent
// RL3: Duty is high time over period
// RL4: Drive output is active high
// RL5: Analog level maps linearly to 30..100 percent
// RL6: Power-up and unshutdown force one-second full drive
// RL7: After kick, select analog or register duty
// RL8: Duty source defaults to analog after reset
// RL9: Open analog input gives 39.33 percent duty
// RL10: Count pulses per fan for RPM
// RL11: Fault low when fan RPM below threshold
// RL12: RPM reveals open, short, locked fans
// RL13: Host reads/writes RPM data and thresholds
// RL14: Analog above top sets over-temperature flag
// RL15: Fault variant pulls fault low on over-temperature
// RL16: Register duty used when source bit set
// RL17: Four-bit duty code, 30 to 100 percent
// RL18: Drive stops only on shutdown bit
// RL19: Locked rotor keeps drive pulsing
// RL20: Kick lasts thirty PWM periods
// RL21: Over-temperature flag sticky until host clears
//
// The register addresses and register access over Avalon-MM were left to the implementer.
`timescale 1ns/100ps
`include "fan_pwm_params.svh"

module fan_pwm_startup_control #(
   parameter int PERIOD_CYC = `PWM_PERIOD_CYC,
   parameter int KICK_PERIODS = `STARTUP_PERIODS,
   parameter bit OTEMP_FAULT = 1'b1
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   output logic [31:0] o_avs_readdata,
   output logic o_avs_waitrequest,
   input wire logic [`ANA_W-1:0] i_analog_duty_in,
   input wire logic i_analog_open,
   input wire logic i_fan1_pulse_in,
   input wire logic i_fan2_pulse_in,
   output logic o_pwm_drive_out,
   output logic o_fault_out,
   output logic o_fault_oe
);
   import fan_pwm_pkg::*;

   localparam int CNT_W = $clog2(PERIOD_CYC + 1);
   localparam logic [`ANA_W-1:0] ANA_MAX = {`ANA_W{1'b1}};

   initial begin
      if (PERIOD_CYC < 100 || KICK_PERIODS < 1) begin
         $error("fan_pwm_startup_control: period or kick length too small");
      end
      // Kick counter is eight bits wide
      if (KICK_PERIODS > 255) begin
         $error("fan_pwm_startup_control: kick length too large");
      end
   end

   // High time in cycles for a fraction num/den between 30 and 100 percent
   function automatic logic [CNT_W-1:0] high_cycles(input logic [31:0] num, input logic [31:0] den);
      logic [63:0] t;
      t = 64'(PERIOD_CYC) * (64'(`DUTY_MIN_PCT) * den + 64'(`DUTY_SPAN_PCT) * num) / (64'd100 * den);
      return CNT_W'(t);
   endfunction

   // Rising edge detect over a synchronised input
   function automatic logic rise(input logic cur, input logic prev);
      return cur & ~prev;
   endfunction

   logic shutdown_request_bit_q;
   logic duty_source_select_q;
   logic [3:0] duty_code_q;
   logic over_temp_flag_q;
   logic [`TACH_W-1:0] fan1_limit_q, fan2_limit_q;
   logic [`TACH_W-1:0] fan1_cnt_q, fan2_cnt_q;
   logic [`TACH_W-1:0] fan1_rpm_q, fan2_rpm_q;
   logic fan1_fail_q, fan2_fail_q;
   logic [2:0] s1_q, s2_q;
   logic [CNT_W-1:0] phase_q;
   logic [CNT_W-1:0] high_q;
   logic [7:0] kick_q;
   logic [4:0] win_q;
   logic win_end;
   logic kick_last;
   logic [`ANA_W-1:0] ana_q;
   logic ana_open_q;
   drive_state_type state_q;
   logic ack_q;
   logic period_end;
   logic bus_req;
   logic wr_en;
   logic otemp_now;

   assign bus_req = (i_avs_read | i_avs_write) & ~ack_q;
   assign wr_en = i_avs_write & ack_q;
   assign period_end = (phase_q == CNT_W'(PERIOD_CYC - 1));
   assign otemp_now = (ana_q == ANA_MAX);
   assign kick_last = (kick_q == 8'(KICK_PERIODS - 1));
   assign win_end = period_end && (win_q == 5'(`TACH_WIN_PERIODS - 1));

   // Two-flop synchronisers plus edge history for tach pins
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         s1_q <= 3'h0;
         s2_q <= 3'h0;
      end else begin
         s1_q <= {s1_q[1:0], i_fan1_pulse_in};
         s2_q <= {s2_q[1:0], i_fan2_pulse_in};
      end
   end

   // Analog code is sampled once per cycle from the converter
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ana_q <= '0;
         ana_open_q <= 1'b0;
      end else begin
         ana_q <= i_analog_duty_in;
         ana_open_q <= i_analog_open;
      end
   end

   // Free-running period counter: frequency never depends on duty
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         phase_q <= '0;
      end else if (state_q == ST_OFF) begin
         phase_q <= '0; // Wake kick starts on a whole period
      end else if (period_end) begin
         phase_q <= '0; // RL1
      end else begin
         phase_q <= phase_q + 1'b1;
      end
   end

   // Drive state: off on shutdown, kick on power-up and on release
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         state_q <= ST_KICK; // RL6
         kick_q <= '0;
      end else begin
         unique case (state_q)
            ST_OFF: begin
               kick_q <= '0;
               if (!shutdown_request_bit_q) begin
                  state_q <= ST_KICK; // RL6
               end
            end
            ST_KICK: begin
               if (shutdown_request_bit_q) begin
                  state_q <= ST_OFF; // RL18
               end else if (period_end) begin
                  if (kick_last) begin
                     state_q <= ST_RUN; // RL20 RL7
                  end
                  kick_q <= kick_q + 8'h01;
               end
            end
            ST_RUN: begin
               if (shutdown_request_bit_q) begin
                  state_q <= ST_OFF; // RL18 RL19
               end
            end
         endcase
      end
   end

   // Duty selection, latched at period start so only high time changes
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         high_q <= CNT_W'(PERIOD_CYC);
      end else if (state_q == ST_OFF) begin
         high_q <= CNT_W'(PERIOD_CYC); // RL6
      end else if (period_end) begin
         if (state_q == ST_KICK && !kick_last) begin
            high_q <= CNT_W'(PERIOD_CYC); // RL6
         end else if (duty_source_select_q) begin
            high_q <= high_cycles(32'(duty_code_q), 32'd15); // RL16 RL17 RL2
         end else if (ana_open_q) begin
            high_q <= high_cycles(32'(`DUTY_OPEN_CODE), 32'd15); // RL9
         end else begin
            high_q <= high_cycles(32'(ana_q), 32'(ANA_MAX)); // RL5 RL2
         end
      end
   end

   // Active-high drive; 100 percent keeps it high the whole period
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_pwm_drive_out <= 1'b0;
      end else begin
         o_pwm_drive_out <= (state_q != ST_OFF) && (phase_q < high_q); // RL3 RL4
      end
   end

   // Measurement window: counts whole PWM periods, independent of the kick
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         win_q <= '0;
      end else if (win_end) begin
         win_q <= '0;
      end else if (period_end) begin
         win_q <= win_q + 5'h01;
      end
   end

   // Fan 1 tach pulse counting, snapshot once per window
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         fan1_cnt_q <= '0;
         fan1_rpm_q <= '0;
      end else if (win_end) begin
         fan1_rpm_q <= fan1_cnt_q; // RL10
         fan1_cnt_q <= '0;
      end else begin
         fan1_cnt_q <= fan1_cnt_q + `TACH_W'(rise(s1_q[1], s1_q[2])); // RL10
      end
   end

   // Fan 2 tach pulse counting, snapshot once per window
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         fan2_cnt_q <= '0;
         fan2_rpm_q <= '0;
      end else if (win_end) begin
         fan2_rpm_q <= fan2_cnt_q; // RL10
         fan2_cnt_q <= '0;
      end else begin
         fan2_cnt_q <= fan2_cnt_q + `TACH_W'(rise(s2_q[1], s2_q[2])); // RL10
      end
   end

   // Fan 1 low RPM covers open, short, missing and locked fans
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         fan1_fail_q <= 1'b0;
      end else begin
         fan1_fail_q <= (state_q == ST_RUN) && (fan1_rpm_q < fan1_limit_q); // RL11 RL12
      end
   end

   // Fan 2 low RPM covers open, short, missing and locked fans
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         fan2_fail_q <= 1'b0;
      end else begin
         fan2_fail_q <= (state_q == ST_RUN) && (fan2_rpm_q < fan2_limit_q); // RL11 RL12
      end
   end

   // Open-drain fault: drive low while any fault stands
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_fault_oe <= 1'b0;
         o_fault_out <= 1'b0;
      end else begin
         o_fault_oe <= fan1_fail_q | fan2_fail_q | (OTEMP_FAULT & otemp_now); // RL11 RL15
         o_fault_out <= 1'b0;
      end
   end

   // Sticky over-temperature flag; set beats a write-one clear
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         over_temp_flag_q <= 1'b0;
      end else if (otemp_now) begin
         over_temp_flag_q <= 1'b1; // RL14
      end else if (wr_en && i_avs_address == `REG_STATUS && i_avs_writedata[`STAT_OTEMP_BIT]) begin
         over_temp_flag_q <= 1'b0; // RL21
      end
   end

   // Control register writes
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         shutdown_request_bit_q <= 1'b0;
         duty_source_select_q <= 1'b0; // RL8
         duty_code_q <= `DUTY_OPEN_CODE;
         fan1_limit_q <= '0;
         fan2_limit_q <= '0;
      end else if (wr_en) begin
         unique case (i_avs_address)
            `REG_CONFIG: begin
               shutdown_request_bit_q <= i_avs_writedata[`CFG_SHUTDOWN_BIT];
               duty_source_select_q <= i_avs_writedata[`CFG_DUTY_SRC_BIT];
            end
            `REG_DUTY: duty_code_q <= i_avs_writedata[3:0]; // RL17
            `REG_FAN1_LIMIT: fan1_limit_q <= i_avs_writedata[`TACH_W-1:0]; // RL13
            `REG_FAN2_LIMIT: fan2_limit_q <= i_avs_writedata[`TACH_W-1:0]; // RL13
            default: begin
            end
         endcase
      end
   end

   // Bus handshake: one wait cycle, then answer
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ack_q <= 1'b0;
         o_avs_waitrequest <= 1'b1;
      end else begin
         ack_q <= bus_req;
         o_avs_waitrequest <= ~bus_req;
      end
   end

   // Read mux; unmapped offsets read zero
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_avs_readdata <= '0;
      end else if (bus_req && i_avs_read) begin
         unique case (i_avs_address)
            `REG_CONFIG: o_avs_readdata <= {26'h0, duty_source_select_q, 4'h0, shutdown_request_bit_q};
            `REG_STATUS: o_avs_readdata <= {26'h0, over_temp_flag_q, 3'h0, fan2_fail_q, fan1_fail_q};
            `REG_DUTY: o_avs_readdata <= {28'h0, duty_code_q};
            `REG_FAN1_RPM: o_avs_readdata <= {16'h0, fan1_rpm_q}; // RL13
            `REG_FAN2_RPM: o_avs_readdata <= {16'h0, fan2_rpm_q};
            `REG_FAN1_LIMIT: o_avs_readdata <= {16'h0, fan1_limit_q};
            `REG_FAN2_LIMIT: o_avs_readdata <= {16'h0, fan2_limit_q};
            default: o_avs_readdata <= 32'h0;
         endcase
      end
   end
endmodule

// ===== verification/fan_tach_model.sv
// Purpose: Fan tach source for the PWM controller bench
// Assumes: Tach rate of one pulse per 160 ns
// Notes: A stalled fan holds its line low
`timescale 1ns/100ps
module fan_tach_model (
   input wire logic i_spin,
   output logic o_pulse
);
   initial o_pulse = 1'b0;
   // Toggle every 80 ns while spinning, rest low when stalled
   always begin
      #80;
      o_pulse = i_spin ? !o_pulse : 1'b0;
   end
endmodule

// ===== verification/fan_pwm_properties.sv
// Purpose: Port assertions for the fan PWM controller
// Assumes: Config writes seen on the bus
// Notes: Shutdown bit is tracked from bus writes
`timescale 1ns/100ps
module fan_pwm_properties #(
   parameter int PERIOD_CYC = 300
) (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [4:0] i_avs_address,
   input wire logic i_avs_read,
   input wire logic i_avs_write,
   input wire logic [31:0] i_avs_writedata,
   input wire logic [31:0] o_avs_readdata,
   input wire logic o_avs_waitrequest,
   input wire logic [7:0] i_analog_duty_in,
   input wire logic i_analog_open,
   input wire logic i_fan1_pulse_in,
   input wire logic i_fan2_pulse_in,
   input wire logic o_pwm_drive_out,
   input wire logic o_fault_out,
   input wire logic o_fault_oe
);
   localparam int LO_MAX = PERIOD_CYC * 70 / 100;
   logic sd_q;
   logic cfg_wr;
   int lo_cnt;
   int rs_cnt;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_sys_rst);
   assign cfg_wr = i_avs_write && !o_avs_waitrequest && i_avs_address == 5'h00;
   // Shutdown copy, low-run length and gap since last rise
   always_ff @(posedge i_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         sd_q <= 1'b0;
         lo_cnt <= 0;
         rs_cnt <= 0;
      end else begin
         if (cfg_wr)
            sd_q <= i_avs_writedata[0];
         lo_cnt <= (o_pwm_drive_out || sd_q) ? 0 : lo_cnt + 1;
         rs_cnt <= (sd_q || cfg_wr) ? 0 : $rose(o_pwm_drive_out) ? 1 : (rs_cnt != 0) ? rs_cnt + 1 : 0;
      end
   end
   sequence s_req;
      (i_avs_read || i_avs_write) && o_avs_waitrequest;
   endsequence
   sequence s_ack;
      !o_avs_waitrequest ##1 o_avs_waitrequest;
   endsequence
   AST_BUS_ONE_WAIT: assert property (s_req |=> s_ack)
      else $error("bus answer late or long");
   AST_READ_STANDS: assert property (!$stable(o_avs_readdata) |-> !o_avs_waitrequest)
      else $error("read data moved outside an answer");
   AST_KICK_RESET: assert property ($fell(i_sys_rst) |-> ##3 o_pwm_drive_out [*8])
      else $error("no full drive after reset");
   AST_KICK_WAKE: assert property (sd_q && cfg_wr && !i_avs_writedata[0] |-> ##3 o_pwm_drive_out [*8])
      else $error("no full drive after wake");
   AST_DUTY_FLOOR: assert property (lo_cnt <= LO_MAX)
      else $error("low time too long");
   AST_PERIOD_FIXED: assert property ($rose(o_pwm_drive_out) && rs_cnt != 0 |-> rs_cnt % PERIOD_CYC == 0)
      else $error("drive period moved");
   AST_OTF_FAULT: assert property (i_analog_duty_in == 8'hFF && !i_analog_open |-> ##[0:700] o_fault_oe)
      else $error("no fault on over temperature");
   AST_FAULT_DATA: assert property (o_fault_oe |-> o_fault_out == 1'b0)
      else $error("fault pin driven high");
endmodule
bind fan_pwm_startup_control fan_pwm_properties #(.PERIOD_CYC(PERIOD_CYC)) u_chk (.i_clk(i_clk),
   .i_sys_rst(i_sys_rst), .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
   .i_avs_writedata(i_avs_writedata), .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
   .i_analog_duty_in(i_analog_duty_in), .i_analog_open(i_analog_open), .i_fan1_pulse_in(i_fan1_pulse_in),
   .i_fan2_pulse_in(i_fan2_pulse_in), .o_pwm_drive_out(o_pwm_drive_out), .o_fault_out(o_fault_out),
   .o_fault_oe(o_fault_oe));

// ===== verification/fan_pwm_startup_control_test.sv
// Purpose: Self-checking bench for the fan PWM controller
// Assumes: Period shortened to 300 cycles, kick to two periods
// Notes: Fan 2 stays stalled as a locked rotor
`timescale 1ns/100ps
`include "fan_pwm_params.svh"
module fan_pwm_startup_control_test;
   localparam int P = 300;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [4:0] addr = 5'h00;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [7:0] ana = 8'h00;
   logic ana_open = 1'b0;
   logic spin1 = 1'b1;
   logic spin2 = 1'b0;
   logic [31:0] rdata;
   logic [31:0] got;
   logic waitreq, tach1, tach2, drive, fault, fault_oe;
   int errors = 0;
   int tests_run = 0;
   int n;
   always #5 clk = !clk;
   fan_pwm_startup_control #(.PERIOD_CYC(P), .KICK_PERIODS(2), .OTEMP_FAULT(1'b1)) u_dut (.i_clk(clk),
      .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wdata),
      .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq), .i_analog_duty_in(ana), .i_analog_open(ana_open),
      .i_fan1_pulse_in(tach1), .i_fan2_pulse_in(tach2), .o_pwm_drive_out(drive), .o_fault_out(fault),
      .o_fault_oe(fault_oe));
   fan_tach_model u_fan1 (.i_spin(spin1), .o_pulse(tach1));
   fan_tach_model u_fan2 (.i_spin(spin2), .o_pulse(tach2));
   task chk(input logic [31:0] g, input logic [31:0] e);
      tests_run++;
      if (g !== e) begin
         errors++;
         $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // Bus cycles hold until waitrequest is sampled low
   task wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr_en <= 1'b1;
      do @(posedge clk); while (waitreq !== 1'b0);
      wr_en <= 1'b0;
   endtask
   task rd(input logic [4:0] a);
      @(posedge clk);
      addr <= a;
      rd_en <= 1'b1;
      do @(posedge clk); while (waitreq !== 1'b0);
      got = rdata;
      rd_en <= 1'b0;
   endtask
   task rdc(input logic [4:0] a, input logic [31:0] e);
      rd(a);
      chk(got, e);
   endtask
   // High cycles of the drive over a window
   task hi(input int w, input int len);
      repeat (w) @(posedge clk);
      got = 32'h0;
      repeat (len) begin
         @(posedge clk);
         got = got + 32'(drive === 1'b1);
      end
   endtask
   task pw(input logic [31:0] e);
      hi(2 * P, P);
      chk(got, e);
   endtask
   task conclude;
      $display("tests %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Watchdog well past the expected 41k cycles
   initial begin
      #700000;
      errors++;
      conclude;
   end
   // Test sequence
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      hi(3, 2 * P - 6);
      chk(got, 32'(2 * P - 6));
      rdc(`REG_CONFIG, 32'h0);
      rdc(`REG_DUTY, 32'h2);
      rdc(5'h1C, 32'h0);
      $display("kick done");
      pw(32'd90);
      ana_open <= 1'b1;
      pw(32'd118);
      ana_open <= 1'b0;
      ana <= 8'hFF;
      pw(32'(P));
      chk(32'(fault_oe), 32'h1);
      rdc(`REG_STATUS, 32'h20);
      ana <= 8'h00;
      pw(32'd90);
      rdc(`REG_STATUS, 32'h20);
      wr(`REG_STATUS, 32'h20);
      rdc(`REG_STATUS, 32'h0);
      chk(32'(fault_oe), 32'h0);
      $display("analog done");
      wr(`REG_CONFIG, 32'h20);
      for (n = 0; n < 16; n++) begin
         wr(`REG_DUTY, 32'(n));
         rdc(`REG_DUTY, 32'(n));
         pw(32'(90 + 14 * n));
      end
      $display("register duty done");
      wr(`REG_CONFIG, 32'h21);
      pw(32'd0);
      wr(`REG_CONFIG, 32'h20);
      hi(3, 2 * P - 6);
      chk(got, 32'(2 * P - 6));
      $display("shutdown done");
      wr(`REG_DUTY, 32'h5);
      wr(`REG_FAN1_LIMIT, 32'h1);
      wr(`REG_FAN2_LIMIT, 32'h1);
      rdc(`REG_FAN1_LIMIT, 32'h1);
      repeat (66 * P) @(posedge clk);
      rd(`REG_FAN1_RPM);
      chk(32'(got >= 598 && got <= 602), 32'h1);
      rdc(`REG_FAN2_RPM, 32'h0);
      rdc(`REG_STATUS, 32'h2);
      chk(32'(fault_oe), 32'h1);
      pw(32'd160);
      $display("tach done");
      conclude;
   end
endmodule
